//--- pkg/stmh_regs.svh
// Message codes, identify field positions and unit number of the target
`ifndef STMH_REGS_SVH
`define STMH_REGS_SVH

// Message codes on the bus
`define STMH_MSG_COMPLETE    8'h00
`define STMH_MSG_EXTENDED    8'h01
`define STMH_MSG_SAVE_PTR    8'h02
`define STMH_MSG_RESTORE     8'h03
`define STMH_MSG_DISCONNECT  8'h04
`define STMH_MSG_INIT_ERROR  8'h05
`define STMH_MSG_ABORT       8'h06
`define STMH_MSG_REJECT      8'h07
`define STMH_MSG_NOP         8'h08
`define STMH_MSG_PARITY_ERR  8'h09
`define STMH_MSG_LINKED      8'h0A
`define STMH_MSG_LINKED_FLAG 8'h0B
`define STMH_MSG_DEV_RESET   8'h0C
`define STMH_MSG_IDENTIFY    8'h80

// Identify byte layout
`define STMH_ID_FLAG_BIT     7
`define STMH_ID_DISC_BIT     6
`define STMH_ID_RSVD_MSB     5
`define STMH_ID_RSVD_LSB     3
`define STMH_ID_LUN_MSB      2
`define STMH_ID_LUN_LSB      0

// Only logical unit served by this target
`define STMH_LUN             3'h0

`endif

//--- pkg/stmh_pkg.sv
// Types of the tape target message handler
package stmh_pkg;

   typedef enum logic [4:0] {
      ST_IDLE     = 5'h01,
      ST_MIN_REQ  = 5'h02,
      ST_MIN_ACK  = 5'h04,
      ST_MOUT_REQ = 5'h08,
      ST_MOUT_ACK = 5'h10
   } stmh_state_e;

   typedef enum logic [2:0] {
      CMD_SELECTED    = 3'h0,
      CMD_RESELECTED  = 3'h1,
      CMD_COMPLETE    = 3'h2,
      CMD_LINKED      = 3'h3,
      CMD_LINKED_FLAG = 3'h4,
      CMD_DISCONNECT  = 3'h5,
      CMD_RESTORE     = 3'h6
   } stmh_cmd_e;

   // Bus pins as seen by the target, asserted = 1
   typedef struct packed {
      logic       rst;
      logic       atn;
      logic       ack;
      logic       par;
      logic [7:0] data;
   } stmh_bus_in_s;

   // Bus pins driven by the target, asserted = 1
   typedef struct packed {
      logic       bsy;
      logic       req;
      logic       cd;
      logic       io;
      logic       msg;
      logic       data_oe;
      logic       par;
      logic [7:0] data;
   } stmh_bus_out_s;

   typedef struct packed {
      logic      valid;
      stmh_cmd_e cmd;
   } stmh_core_req_s;

   typedef struct packed {
      logic ready;
      logic done;
      logic cmd_phase;
      logic retransmit;
      logic abort;
      logic abort_lun;
      logic dev_reset;
      logic init_reject;
      logic bus_free;
      logic identified;
      logic disc_ok;
   } stmh_core_ans_s;

   typedef struct packed {
      stmh_state_e    st;
      stmh_bus_in_s   s1;
      stmh_bus_in_s   s2;
      stmh_bus_in_s   s3;
      stmh_bus_in_s   pin;
      logic [7:0]     last_in;
      logic [7:0]     rx;
      logic           rx_par;
      logic           first_out;
      logic           chain;
      logic           retx;
      stmh_bus_out_s  bus;
      stmh_core_ans_s ans;
   } stmh_state_s;

endpackage : stmh_pkg

//--- hdl/stmh_msg_handler.sv
// Message phase handler of the tape target on the parallel bus
`timescale 1ns/1ps
`include "stmh_regs.svh"

// Contract
// - Selection with attention: target enters Message Out, initiator sends Identify.
// - First message after selection may be Abort or Bus Device Reset.
// - After reselection the target sends Identify first.
// - After status, send completion 00H, then release busy to Bus Free.
// - Code 01H opens an extended message; synchronous request not supported.
// - Send save-data-pointer 02H before each splitting disconnect.
// - Send disconnect 04H, then release busy.
// - On 05H restore pointers by message, then retransmit.
// - Abort 06H clears this initiator's work, Bus Free, no status.
// - Reject 07H an inappropriate or unsupported received message.
// - To reject, go to Message In and send reject before more requests.
// - After 09H the target returns to Message In and resends.
// - After 0AH or 0BH go to command phase without Bus Free.
// - Bus Device Reset 0CH clears all commands, initial state, Bus Free.
// - Identify: bit 7 one, bits 5..3 zero, bits 2..0 unit number.
// - Disconnect bit of Identify is set only by the initiator.
// - Unit number must be zero; one unit identified per selection.
// - Keep requesting Message Out bytes while attention stays asserted.
module stmh_msg_handler
   import stmh_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           nrst,
   input  wire stmh_bus_in_s   bus_i,
   output      stmh_bus_out_s  bus_o,
   input  wire stmh_core_req_s core_i,
   output      stmh_core_ans_s core_o
);

   stmh_state_s r;
   stmh_state_s next_r;
   logic        rx_good;
   logic        first_ok;
   logic        id_ok;

   // Odd parity bit for a byte
   function automatic logic odd_par(input logic [7:0] b);
      return ~(^b);
   endfunction : odd_par

   // Message In drive of one byte
   function automatic stmh_bus_out_s drive_in(input logic [7:0] b);
      stmh_bus_out_s o;
      o         = '0;
      o.bsy     = 1'b1;
      o.req     = 1'b1;
      o.cd      = 1'b1;
      o.io      = 1'b1;
      o.msg     = 1'b1;
      o.data_oe = 1'b1;
      o.data    = b;
      o.par     = odd_par(b);
      return o;
   endfunction : drive_in

   // Start sending a message byte
   function automatic stmh_state_s send(input stmh_state_s s,
                                        input logic [7:0]  b);
      stmh_state_s t;
      t         = s;
      t.bus     = drive_in(b);
      t.last_in = b;
      t.st      = ST_MIN_REQ;
      return t;
   endfunction : send

   // Request a Message Out byte
   function automatic stmh_state_s recv(input stmh_state_s s);
      stmh_state_s t;
      t         = s;
      t.bus     = '0;
      t.bus.bsy = 1'b1;
      t.bus.req = 1'b1;
      t.bus.cd  = 1'b1;
      t.bus.msg = 1'b1;
      t.st      = ST_MOUT_REQ;
      return t;
   endfunction : recv

   // Release every bus line and forget the connection
   function automatic stmh_state_s go_free(input stmh_state_s s);
      stmh_state_s t;
      t                = s;
      t.bus            = '0;
      t.st             = ST_IDLE;
      t.first_out      = 1'b0;
      t.chain          = 1'b0;
      t.retx           = 1'b0;
      t.ans.identified = 1'b0;
      t.ans.disc_ok    = 1'b0;
      t.ans.bus_free   = 1'b1;
      return t;
   endfunction : go_free

   // End of a message phase: queued disconnect or hand back to the core
   function automatic stmh_state_s finish(input stmh_state_s s);
      stmh_state_s t;
      t = s;
      if (s.chain) begin
         t.chain = 1'b0;
         t       = send(t, `STMH_MSG_DISCONNECT);
      end else begin
         t.bus      = '0;
         t.bus.bsy  = 1'b1;
         t.st       = ST_IDLE;
         t.ans.done = 1'b1;
      end
      return t;
   endfunction : finish

   // Keep requesting while attention stays up, else finish
   function automatic stmh_state_s cont(input stmh_state_s s,
                                        input logic        atn);
      stmh_state_s t;
      if (atn) begin
         t = recv(s);
      end else begin
         t = finish(s);
      end
      return t;
   endfunction : cont

   // Received byte checks
   assign rx_good  = ^{r.rx_par, r.rx};
   assign first_ok = r.rx[`STMH_ID_FLAG_BIT] ||
                     (r.rx == `STMH_MSG_ABORT) ||
                     (r.rx == `STMH_MSG_DEV_RESET);
   assign id_ok    = (r.rx[`STMH_ID_RSVD_MSB:`STMH_ID_RSVD_LSB] == 3'h0) &&
                     (r.rx[`STMH_ID_LUN_MSB:`STMH_ID_LUN_LSB] == `STMH_LUN) &&
                     !r.ans.identified;

   // Next state of the handler
   always_comb begin
      next_r                 = r;
      next_r.s1              = bus_i;
      next_r.s2              = r.s1;
      next_r.s3              = r.s2;
      if (r.s2 == r.s3) begin
         next_r.pin = r.s3;
      end
      next_r.ans.done        = 1'b0;
      next_r.ans.cmd_phase   = 1'b0;
      next_r.ans.retransmit  = 1'b0;
      next_r.ans.abort       = 1'b0;
      next_r.ans.abort_lun   = 1'b0;
      next_r.ans.dev_reset   = 1'b0;
      next_r.ans.init_reject = 1'b0;
      next_r.ans.bus_free    = 1'b0;
      if (r.pin.rst) begin
         next_r               = go_free(next_r);
         next_r.ans.dev_reset = 1'b1;
      end else begin
         case (r.st)
            ST_IDLE: begin
               if (core_i.valid) begin
                  case (core_i.cmd)
                     CMD_SELECTED: begin
                        next_r.bus.bsy   = 1'b1;
                        next_r.first_out = 1'b1;
                        if (r.pin.atn) begin
                           next_r = recv(next_r);
                        end else begin
                           next_r.ans.done = 1'b1;
                        end
                     end
                     CMD_RESELECTED: begin
                        // Bit 6 stays clear on our own Identify
                        next_r = send(next_r, `STMH_MSG_IDENTIFY |
                                      {5'h00, `STMH_LUN});
                        next_r.ans.identified = 1'b1;
                     end
                     CMD_COMPLETE: begin
                        next_r = send(next_r, `STMH_MSG_COMPLETE);
                     end
                     CMD_LINKED: begin
                        next_r = send(next_r, `STMH_MSG_LINKED);
                     end
                     CMD_LINKED_FLAG: begin
                        next_r = send(next_r, `STMH_MSG_LINKED_FLAG);
                     end
                     CMD_DISCONNECT: begin
                        next_r       = send(next_r, `STMH_MSG_SAVE_PTR);
                        next_r.chain = 1'b1;
                     end
                     CMD_RESTORE: begin
                        next_r = send(next_r, `STMH_MSG_RESTORE);
                     end
                     default: begin
                        next_r.ans.done = 1'b1;
                     end
                  endcase
               end
            end
            ST_MIN_REQ: begin
               if (r.pin.ack) begin
                  next_r.bus.req = 1'b0;
                  next_r.st      = ST_MIN_ACK;
               end
            end
            ST_MIN_ACK: begin
               if (!r.pin.ack) begin
                  if (r.pin.atn) begin
                     // Attention raised before ack fell names this byte
                     next_r = recv(next_r);
                  end else if (r.chain) begin
                     next_r = finish(next_r);
                  end else begin
                     case (r.last_in)
                        `STMH_MSG_COMPLETE, `STMH_MSG_DISCONNECT: begin
                           next_r = go_free(next_r);
                        end
                        `STMH_MSG_LINKED, `STMH_MSG_LINKED_FLAG: begin
                           next_r               = finish(next_r);
                           next_r.ans.done      = 1'b0;
                           next_r.ans.cmd_phase = 1'b1;
                        end
                        `STMH_MSG_RESTORE: begin
                           next_r                = finish(next_r);
                           next_r.ans.retransmit = r.retx;
                           next_r.retx           = 1'b0;
                        end
                        default: begin
                           next_r = finish(next_r);
                        end
                     endcase
                  end
               end
            end
            ST_MOUT_REQ: begin
               if (r.pin.ack) begin
                  next_r.rx      = r.pin.data;
                  next_r.rx_par  = r.pin.par;
                  next_r.bus.req = 1'b0;
                  next_r.st      = ST_MOUT_ACK;
               end
            end
            ST_MOUT_ACK: begin
               if (!r.pin.ack) begin
                  if (!rx_good) begin
                     next_r = recv(next_r); // Bad parity, ask again
                  end else if (r.first_out && !first_ok) begin
                     next_r.first_out = 1'b0;
                     next_r = send(next_r, `STMH_MSG_REJECT);
                  end else begin
                     next_r.first_out = 1'b0;
                     if (r.rx[`STMH_ID_FLAG_BIT]) begin
                        if (id_ok) begin
                           next_r.ans.identified = 1'b1;
                           next_r.ans.disc_ok = r.rx[`STMH_ID_DISC_BIT];
                           next_r = cont(next_r, r.pin.atn);
                        end else begin
                           next_r = send(next_r, `STMH_MSG_REJECT);
                        end
                     end else begin
                        case (r.rx)
                           `STMH_MSG_ABORT: begin
                              next_r               = go_free(next_r);
                              next_r.ans.abort     = 1'b1;
                              next_r.ans.abort_lun = r.ans.identified;
                           end
                           `STMH_MSG_DEV_RESET: begin
                              next_r               = go_free(next_r);
                              next_r.ans.dev_reset = 1'b1;
                           end
                           `STMH_MSG_INIT_ERROR: begin
                              next_r.retx = 1'b1;
                              next_r = send(next_r, `STMH_MSG_RESTORE);
                           end
                           `STMH_MSG_REJECT: begin
                              next_r.ans.init_reject = 1'b1;
                              next_r = cont(next_r, r.pin.atn);
                           end
                           `STMH_MSG_NOP: begin
                              next_r = cont(next_r, r.pin.atn);
                           end
                           `STMH_MSG_PARITY_ERR: begin
                              next_r = send(next_r, r.last_in);
                           end
                           default: begin
                              // Extended, unknown rejected
                              next_r = send(next_r, `STMH_MSG_REJECT);
                              // Reject before more requests
                           end
                        endcase
                     end
                  end
               end
            end
            default: begin
               next_r = go_free(next_r);
            end
         endcase
      end
      next_r.ans.ready = (next_r.st == ST_IDLE);
   end

   // State register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r           <= '0;
         r.st        <= ST_IDLE;
         r.ans.ready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign bus_o  = r.bus;
   assign core_o = r.ans;

   // Checks on the handler
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_SEL_MOUT: assert property (
      r.st == ST_IDLE && core_i.valid && core_i.cmd == CMD_SELECTED &&
      r.pin.atn && !r.pin.rst |=> bus_o.req && bus_o.msg && !bus_o.io)
      else $error("selection with attention did not enter message out");

   AST_RESEL_ID: assert property (
      r.st == ST_IDLE && core_i.valid && core_i.cmd == CMD_RESELECTED &&
      !r.pin.rst |=> bus_o.req && bus_o.io && bus_o.data == 8'h80)
      else $error("reselection did not send identify first");

   AST_COMPLETE_FREE: assert property (
      r.st == ST_MIN_ACK && r.last_in == `STMH_MSG_COMPLETE && !r.chain &&
      !r.pin.ack && !r.pin.atn && !r.pin.rst |=> !bus_o.bsy ##1 !bus_o.bsy)
      else $error("busy not released after completion message");

   AST_SAVE_THEN_DISC: assert property (
      r.st == ST_MIN_ACK && r.chain && !r.pin.ack && !r.pin.atn &&
      !r.pin.rst |=> bus_o.req && bus_o.data == `STMH_MSG_DISCONNECT)
      else $error("disconnect did not follow save pointer");

   AST_IDE_RESTORE: assert property (
      r.st == ST_MOUT_ACK && !r.pin.ack && rx_good && !r.first_out &&
      r.rx == `STMH_MSG_INIT_ERROR && !r.pin.rst
      |=> bus_o.req && bus_o.data == `STMH_MSG_RESTORE)
      else $error("initiator error not answered by restore pointers");

   AST_ABORT_FREE: assert property (
      r.st == ST_MOUT_ACK && !r.pin.ack && rx_good &&
      r.rx == `STMH_MSG_ABORT && !r.pin.rst
      |=> !bus_o.bsy && core_o.abort && !bus_o.req)
      else $error("abort did not free the bus");

   AST_EXT_REJECT: assert property (
      r.st == ST_MOUT_ACK && !r.pin.ack && rx_good &&
      r.rx == `STMH_MSG_EXTENDED && !r.pin.rst
      |=> bus_o.io && bus_o.data == `STMH_MSG_REJECT)
      else $error("extended message not rejected");

   AST_PARITY_RESEND: assert property (
      r.st == ST_MOUT_ACK && !r.pin.ack && rx_good && !r.first_out &&
      r.rx == `STMH_MSG_PARITY_ERR && !r.pin.rst
      |=> bus_o.io && bus_o.data == $past(r.last_in))
      else $error("message not resent after parity error message");

   AST_LINK_NO_FREE: assert property (
      r.st == ST_MIN_ACK && !r.pin.ack && !r.pin.atn && !r.chain &&
      !r.pin.rst && (r.last_in == `STMH_MSG_LINKED ||
      r.last_in == `STMH_MSG_LINKED_FLAG) |=> bus_o.bsy && core_o.cmd_phase)
      else $error("linked completion passed through bus free");

   AST_MOUT_KEEP: assert property (
      r.st == ST_MOUT_ACK && !r.pin.ack && rx_good && !r.first_out &&
      r.rx == `STMH_MSG_NOP && r.pin.atn && !r.pin.rst
      |=> r.st == ST_MOUT_REQ && bus_o.req)
      else $error("message out stopped while attention held");

endmodule : stmh_msg_handler

//--- tb/stmh_init_model.sv
// Behavioural initiator facing the message handler
`timescale 1ns/1ps
module stmh_init_model
   import stmh_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire stmh_bus_out_s bus_o,
   output      stmh_bus_in_s  bus_i,
   input  wire logic          rst_i,
   input  wire logic          go,
   input  wire logic [31:0]   tx,
   input  wire logic [2:0]    tx_n,
   input  wire logic          par_bad,
   output      logic [15:0]   rx_hist,
   output      logic [7:0]    rx_cnt
);
   logic       ack      = 1'b0;
   logic       par      = 1'b0;
   logic [7:0] dat      = 8'h5A;
   logic       slow     = 1'b0;
   logic       bad_used = 1'b0;
   logic [2:0] sent     = 3'h0;
   logic [7:0] d;
   int         k;

   // Attention held while bytes remain, so up before ack drops
   assign bus_i = '{rst: rst_i, atn: go && (sent < tx_n), ack: ack,
                    par: par, data: dat};

   // One handshake per byte, alternately prompt and slow
   always begin
      @(posedge clk);
      if (!go) begin
         sent = 3'h0;
         bad_used = 1'b0;
      end
      if (nrst && bus_o.req) begin
         repeat (slow ? 6 : 1) @(posedge clk);
         if (bus_o.io) begin
            rx_hist <= {rx_hist[7:0], bus_o.data};
            rx_cnt  <= rx_cnt + 8'h01;
         end else begin
            d = tx[8*sent +: 8];
            dat <= d;
            par <= ~^d ^ (par_bad && !bad_used);
         end
         ack <= 1'b1;
         for (k = 0; k < 60 && bus_o.req; k++) @(posedge clk);
         if (!bus_o.io && par_bad && !bad_used) bad_used = 1'b1;
         else if (!bus_o.io) sent = sent + 3'h1;
         @(posedge clk);
         // Released lines no longer show the byte
         ack  <= 1'b0;
         dat  <= ~dat;
         slow <= ~slow;
      end
   end

   // Receive history starts empty
   initial begin
      rx_hist = 16'hFFFF;
      rx_cnt  = 8'h00;
   end
endmodule : stmh_init_model

//--- tb/scsi_target_message_handler_tb.sv
// Self-checking bench of the tape target message handler
`timescale 1ns/1ps
`include "stmh_regs.svh"
module scsi_target_message_handler_tb;
   import stmh_pkg::*;
   logic           clk     = 1'b0;
   logic           nrst    = 1'b0;
   logic           clr     = 1'b1;
   logic           rst_i   = 1'b0;
   logic           go      = 1'b0;
   logic           par_bad = 1'b0;
   logic [31:0]    tx      = 32'h0;
   logic [2:0]     tx_n    = 3'h0;
   stmh_core_req_s core_i  = '{valid: 1'b0, cmd: CMD_SELECTED};
   stmh_bus_in_s   bus_i;
   stmh_bus_out_s  bus_o;
   stmh_core_ans_s core_o;
   stmh_core_ans_s seen;
   logic [3:0]     ph_in;
   logic [3:0]     ph_out;
   logic [15:0]    rx_hist;
   logic [7:0]     rx_cnt;
   logic [7:0]     c0;
   int             err_total = 0;
   int             n_tests   = 0;

   always #50 clk = ~clk;

   // Sticky answer pulses and phase lines of each direction
   always @(posedge clk) begin
      seen <= clr ? '0 : (seen | core_o);
      if (bus_o.req && bus_o.io) ph_in <= {bus_o.cd, 1'b1, bus_o.msg, bus_o.data_oe};
      if (bus_o.req && !bus_o.io) ph_out <= {bus_o.cd, 1'b0, bus_o.msg, bus_o.data_oe};
   end

   stmh_msg_handler u_dut (.clk(clk), .nrst(nrst), .bus_i(bus_i),
      .bus_o(bus_o), .core_i(core_i), .core_o(core_o));
   stmh_init_model u_ini (.clk(clk), .nrst(nrst), .bus_o(bus_o),
      .bus_i(bus_i), .rst_i(rst_i), .go(go), .tx(tx), .tx_n(tx_n),
      .par_bad(par_bad), .rx_hist(rx_hist), .rx_cnt(rx_cnt));

   task automatic chk(input string nm, input logic [15:0] exp,
                      input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   // One core request with the initiator primed beforehand
   task automatic run(input stmh_cmd_e c, input logic [31:0] t,
                      input logic [2:0] n, input logic bad);
      int i;
      @(posedge clk);
      clr     <= 1'b1;
      tx      <= t;
      tx_n    <= n;
      par_bad <= bad;
      go      <= (n != 3'h0);
      repeat (6) @(posedge clk);
      c0     = rx_cnt;
      clr    <= 1'b0;
      core_i <= '{valid: 1'b1, cmd: c};
      @(posedge clk);
      core_i.valid <= 1'b0;
      repeat (2) @(posedge clk);
      for (i = 0; i < 600 && core_o.ready !== 1'b1; i++) @(posedge clk);
      if (core_o.ready !== 1'b1) begin
         err_total++;
         report_and_stop();
      end
      repeat (10) @(posedge clk);
      go <= 1'b0;
   endtask : run

   task automatic t_complete;
      run(CMD_COMPLETE, 32'h0, 3'h0, 1'b0);
      chk("complete", `STMH_MSG_COMPLETE, rx_hist[7:0]);
      chk("msg in lines", 4'hF, ph_in);
      chk("free", 1'b1, seen.bus_free);
      chk("busy", 1'b0, bus_o.bsy);
   endtask : t_complete

   task automatic t_identify;
      run(CMD_SELECTED, {29'h0, `STMH_LUN} | 32'hC0, 3'h1, 1'b0);
      chk("msg out lines", 4'hA, ph_out);
      chk("no reject", c0, rx_cnt);
      chk("ident", 1'b1, core_o.identified);
      chk("disc ok", 1'b1, core_o.disc_ok);
      t_complete();
      run(CMD_SELECTED, 32'h0880, 3'h2, 1'b1);
      chk("ident nop", c0, rx_cnt);
      chk("no disc", 1'b0, core_o.disc_ok);
      t_complete();
   endtask : t_identify

   task automatic t_rejects;
      logic [7:0] bad_msg [5] = '{8'h08, 8'h81, 8'h88, 8'h01, 8'h84};
      foreach (bad_msg[j]) begin
         run(CMD_SELECTED, {24'h0, bad_msg[j]}, 3'h1, 1'b0);
         chk("reject", `STMH_MSG_REJECT, rx_hist[7:0]);
         chk("msg in", 4'hF, ph_in);
         t_complete();
      end
   endtask : t_rejects

   task automatic t_abort;
      run(CMD_SELECTED, 32'h06, 3'h1, 1'b0);
      chk("abort", 1'b1, seen.abort);
      chk("abort lun", 1'b0, seen.abort_lun);
      chk("no status", c0, rx_cnt);
      chk("free", 1'b1, seen.bus_free);
      run(CMD_SELECTED, 32'h0680, 3'h2, 1'b0);
      chk("abort lun", 1'b1, seen.abort_lun);
      run(CMD_SELECTED, 32'h0C, 3'h1, 1'b0);
      chk("dev reset", 1'b1, seen.dev_reset);
      chk("free", 1'b1, seen.bus_free);
      clr   <= 1'b1;
      rst_i <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (8) @(posedge clk);
      chk("bus rst", 1'b1, seen.dev_reset);
      chk("released", 15'h0, bus_o);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : t_abort

   task automatic t_target_msgs;
      run(CMD_RESELECTED, 32'h0, 3'h0, 1'b0);
      chk("resel", {5'h10, `STMH_LUN}, rx_hist[7:0]);
      t_complete();
      run(CMD_DISCONNECT, 32'h0, 3'h0, 1'b0);
      chk("save disc", 16'h0204, rx_hist);
      chk("disc free", 1'b1, seen.bus_free);
      run(CMD_LINKED, 32'h0, 3'h0, 1'b0);
      chk("linked", `STMH_MSG_LINKED, rx_hist[7:0]);
      chk("cmd phase", 2'h2, {seen.cmd_phase, seen.bus_free});
      run(CMD_LINKED_FLAG, 32'h0, 3'h0, 1'b0);
      chk("linked flag", `STMH_MSG_LINKED_FLAG, rx_hist[7:0]);
      chk("cmd phase", 2'h2, {seen.cmd_phase, seen.bus_free});
      t_complete();
   endtask : t_target_msgs

   task automatic t_retry;
      run(CMD_COMPLETE, 32'h09, 3'h1, 1'b0);
      chk("resent", 16'h0000, rx_hist);
      chk("count", c0 + 8'h02, rx_cnt);
      run(CMD_COMPLETE, 32'h07, 3'h1, 1'b0);
      chk("init reject", 1'b1, seen.init_reject);
      chk("no free", 1'b0, seen.bus_free);
      run(CMD_RESTORE, 32'h0, 3'h0, 1'b0);
      chk("restore only", 16'h0003, rx_hist);
      chk("no retx", 1'b0, seen.retransmit);
      run(CMD_COMPLETE, 32'h05, 3'h1, 1'b0);
      chk("restore", 16'h0003, rx_hist);
      chk("retransmit", 1'b1, seen.retransmit);
      t_complete();
   endtask : t_retry

   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      chk("ready", 1'b1, core_o.ready);
      t_complete();
      t_identify();
      t_rejects();
      t_abort();
      t_target_msgs();
      t_retry();
      report_and_stop();
   end
endmodule : scsi_target_message_handler_tb
